// ==== hdl/lbc_pkg.sv ====
// Purpose: Constants and types for the local bus control block
// Assumes: One clock at 50 MHz, inputs synchronous to it
// Notes:   Shared by lbc_top and lbc_hold_arb
package lbc_pkg;
    localparam logic [7:0] LBC_ERR_INT_TYPE = 8'h10;
    localparam int         LBC_CLK_MHZ      = 50;

    typedef enum logic [1:0] {
        LBC_XFER_WORD,
        LBC_XFER_EVEN,
        LBC_XFER_ODD,
        LBC_XFER_REFRESH
    } lbc_xfer_t;

    typedef enum logic [1:0] {
        LBC_OWN_CORE,
        LBC_OWN_FLOAT,
        LBC_OWN_GRANT
    } lbc_own_t;
endpackage : lbc_pkg

// ==== hdl/lbc_hold_if.sv ====
// Purpose: Hold handover signals between top and arbiter
// Assumes: Single clock domain
// Notes:   Top drives requests in, arbiter answers
`timescale 1ns/100ps
`default_nettype none
interface lbc_hold_if;
    logic hold_req;
    logic boundary;
    logic locked;
    logic bus_float;
    logic grant;
    modport arb (input hold_req, boundary, locked, output bus_float, grant);
    modport top (output hold_req, boundary, locked, input bus_float, grant);
endinterface : lbc_hold_if
`default_nettype wire

// ==== hdl/lbc_hold_arb.sv ====
// Purpose: Hold request arbitration and bus release sequencing
// Assumes: Request held high by the other master while it owns the bus
// Notes:   Float precedes grant by one cycle, grant drops in the same cycle as float
`timescale 1ns/100ps
`default_nettype none
module lbc_hold_arb
    import lbc_pkg::*;
(
    input  wire logic   clk_i,  // Clock
    input  wire logic   rst_i,  // Async reset, high
    lbc_hold_if.arb     hif     // Handover signals
);
    lbc_own_t own_q;

    // ------------------------------------------------------------
    // Ownership sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            own_q <= LBC_OWN_CORE;
        end else begin
            unique case (own_q)
                LBC_OWN_CORE: begin
                    if (hif.hold_req && hif.boundary && !hif.locked) begin
                        own_q <= LBC_OWN_FLOAT;
                    end
                end
                LBC_OWN_FLOAT: begin
                    own_q <= hif.hold_req ? LBC_OWN_GRANT : LBC_OWN_CORE;
                end
                LBC_OWN_GRANT: begin
                    if (!hif.hold_req) begin
                        own_q <= LBC_OWN_CORE;
                    end
                end
                default: own_q <= LBC_OWN_CORE;
            endcase
        end
    end

    assign hif.bus_float = (own_q != LBC_OWN_CORE);
    assign hif.grant     = (own_q == LBC_OWN_GRANT);
endmodule : lbc_hold_arb
`default_nettype wire

// ==== hdl/lbc_top.sv ====
// Purpose: Local bus control strobes, transceiver control, lock and hold
// Assumes: Core supplies one cycle request with its kind; inputs synchronous
// Notes:   Byte-bus variant chosen by parameter BYTE_BUS
`timescale 1ns/100ps
`default_nettype none
module lbc_top
    import lbc_pkg::*;
#(
    parameter bit BYTE_BUS = 1'b0
)(
    input  wire logic       core_clk_i,               // Clock
    input  wire logic       rst_i,                    // Async reset, high
    input  wire logic       external_reset_n_i,       // External reset, low
    input  wire logic       cyc_start_i,              // Core starts a bus cycle
    input  wire lbc_xfer_t  cyc_kind_i,               // Word/even/odd/refresh
    input  wire logic       cyc_write_i,              // Cycle is a write
    input  wire logic       cyc_coproc_i,             // Cycle targets coprocessor
    input  wire logic       cyc_lock_i,               // Cycle is locked
    input  wire logic       ignore_ready_i,           // Chip select ignores ready
    input  wire logic       instr_boundary_i,         // Core at instruction boundary
    input  wire logic       numeric_start_i,          // Numerics operation begins
    input  wire logic       ready_i,                  // Ready from the bus
    input  wire logic       hold_i,                   // Bus request from master
    input  wire logic       coproc_error_n_i,         // Coprocessor error, low
    output logic            cyc_busy_o,               // Bus cycle in progress
    output logic            cyc_done_o,               // Bus cycle ends, pulse
    output logic            a0_o,                     // Address bit zero
    output logic            upper_byte_enable_n_o,    // Upper byte enable or refresh
    output logic            read_n_o,                 // Read strobe
    output logic            write_n_o,                // Write strobe
    output logic            transceiver_enable_n_o,   // Transceiver enable
    output logic            transceiver_direction_o,  // High transmit, low receive
    output logic            lock_n_o,                 // Lock pin output
    output logic            lock_oe_n_o,              // Lock pin enable, low drives
    output logic            ctrl_oe_n_o,              // Control/data enable, low drives
    output logic            bus_grant_o,              // Bus grant
    output logic            coproc_select_n_o,        // Coprocessor select
    output logic            err_int_o,                // Error interrupt request, pulse
    output logic [7:0]      err_int_type_o            // Interrupt type
);
    // ------------------------------------------------------------
    // Local types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LBC_IDLE,
        LBC_ADDR,
        LBC_DATA
    } lbc_state_t;

    lbc_state_t  st_q;
    lbc_xfer_t   kind_q;
    logic        wr_q;
    logic        cop_q;
    logic        lock_q;
    logic        ign_q;
    logic        int_q;
    logic        take;
    logic        finish;
    logic        data_ph;
    logic        act;
    lbc_hold_if  hif ();

    // Cycle accepted only when idle and the bus is still ours
    assign take   = (st_q == LBC_IDLE) && cyc_start_i && !hif.bus_float;
    assign finish = (st_q == LBC_DATA) && (ready_i || ign_q);

    // ------------------------------------------------------------
    // Hold arbitration
    // ------------------------------------------------------------
    assign hif.hold_req = hold_i;
    assign hif.boundary = instr_boundary_i && (st_q == LBC_IDLE) && !cyc_start_i;
    assign hif.locked   = lock_q || cyc_lock_i;

    lbc_hold_arb u_arb (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .hif   (hif)
    );

    // ------------------------------------------------------------
    // Bus cycle sequence
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= LBC_IDLE;
        end else begin
            unique case (st_q)
                LBC_IDLE: begin
                    if (take) begin
                        st_q <= LBC_ADDR;
                    end
                end
                LBC_ADDR: begin
                    st_q <= LBC_DATA;
                end
                LBC_DATA: begin
                    if (finish) begin
                        st_q <= LBC_IDLE;
                    end
                end
                default: begin
                    st_q <= LBC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            kind_q <= LBC_XFER_WORD;
            wr_q   <= 1'b0;
            cop_q  <= 1'b0;
            ign_q  <= 1'b0;
        end else if (take) begin
            kind_q <= cyc_kind_i;
            wr_q   <= cyc_write_i;
            cop_q  <= cyc_coproc_i;
            ign_q  <= ignore_ready_i;
        end
    end

    // Lock held through the locked cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_q <= 1'b0;
        end else if (take) begin
            lock_q <= cyc_lock_i;
        end else if (finish) begin
            lock_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Cycle status
    // ------------------------------------------------------------
    assign cyc_busy_o = (st_q != LBC_IDLE);
    assign cyc_done_o = finish;
    assign data_ph    = (st_q == LBC_DATA) && (kind_q != LBC_XFER_REFRESH);
    assign act        = (st_q != LBC_IDLE);

    // ------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a0_o                  <= 1'b1;
            upper_byte_enable_n_o <= 1'b1;
        end else begin
            a0_o <= act && (kind_q == LBC_XFER_ODD || kind_q == LBC_XFER_REFRESH);
            if (BYTE_BUS) begin
                // Pin serves as refresh_strobe_n on the byte bus
                upper_byte_enable_n_o <= !(act && kind_q == LBC_XFER_REFRESH);
            end else begin
                upper_byte_enable_n_o <= !(act && (kind_q == LBC_XFER_WORD
                                         || kind_q == LBC_XFER_ODD));
            end
        end
    end

    // ------------------------------------------------------------
    // Read and write strobes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            read_n_o  <= 1'b1;
            write_n_o <= 1'b1;
        end else begin
            read_n_o  <= !(data_ph && !wr_q);
            write_n_o <= !(data_ph && wr_q);
        end
    end

    // ------------------------------------------------------------
    // Transceiver control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            transceiver_enable_n_o  <= 1'b1;
            transceiver_direction_o <= 1'b0;
        end else begin
            transceiver_enable_n_o <= !data_ph;
            if (act) begin
                transceiver_direction_o <= wr_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Coprocessor select
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            coproc_select_n_o <= 1'b1;
        end else begin
            coproc_select_n_o <= BYTE_BUS ? 1'b1 : !(act && cop_q);
        end
    end

    // ------------------------------------------------------------
    // Lock pin and bus release
    // ------------------------------------------------------------
    assign lock_n_o    = !lock_q;
    assign lock_oe_n_o = !external_reset_n_i || hif.bus_float;
    assign ctrl_oe_n_o = hif.bus_float;
    assign bus_grant_o = hif.grant;

    // ------------------------------------------------------------
    // Coprocessor error
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_q <= 1'b0;
        end else begin
            int_q <= !BYTE_BUS && numeric_start_i && !coproc_error_n_i;
        end
    end

    assign err_int_o      = int_q;
    assign err_int_type_o = LBC_ERR_INT_TYPE;
endmodule : lbc_top
`default_nettype wire

// ==== dv/lbc_bus_model.sv ====
// Purpose: Far-side bus model answering ready
// Assumes: Busy marks a cycle in progress
// Notes:   Ready after wait_i cycles of busy; silent when en_i low
`timescale 1ns/100ps
`default_nettype none
module lbc_bus_model (
    input  wire logic       clk_i,   // Clock
    input  wire logic       busy_i,  // Cycle in progress
    input  wire logic       en_i,    // Answer enabled
    input  wire logic [3:0] wait_i,  // Wait cycles
    output logic            ready_o  // Ready to block
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i) begin
        cnt_q <= busy_i ? cnt_q + 4'h1 : 4'h0;
    end
    assign ready_o = en_i && busy_i && (cnt_q >= wait_i);
endmodule : lbc_bus_model
`default_nettype wire

// ==== dv/lbc_checker.sv ====
// Purpose: Port assertions for lbc_top
// Assumes: Default byte lanes, one clock
// Notes:   Bound into lbc_top below
`timescale 1ns/100ps
`default_nettype none
module lbc_checker
    import lbc_pkg::*;
(
    input wire logic core_clk_i, rst_i, external_reset_n_i, cyc_start_i,   // Inputs
    input wire lbc_xfer_t cyc_kind_i,                                        // Kind
    input wire logic cyc_coproc_i, cyc_lock_i, ignore_ready_i, ready_i,     // Inputs
    input wire logic instr_boundary_i, numeric_start_i, hold_i, coproc_error_n_i, // Inputs
    input wire logic cyc_busy_o, cyc_done_o, a0_o, upper_byte_enable_n_o,   // Outputs
    input wire logic read_n_o, write_n_o, transceiver_enable_n_o, lock_n_o,  // Outputs
    input wire logic transceiver_direction_o, lock_oe_n_o, ctrl_oe_n_o,     // Outputs
    input wire logic bus_grant_o, coproc_select_n_o, err_int_o,             // Outputs
    input wire logic [7:0] err_int_type_o                                    // Type
);
    wire logic  take = cyc_start_i && !cyc_busy_o && !ctrl_oe_n_o;
    logic [2:0] cyc_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) cyc_q <= 3'h0;
        else if (take) cyc_q <= {cyc_kind_i, cyc_coproc_i};
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    chk_done_ready: assert property (cyc_done_o |-> ready_i || ignore_ready_i)
        else $error("cycle ended without ready");
    chk_take_wait: assert property (take |=> cyc_busy_o && !cyc_done_o)
        else $error("cycle ended too early");
    chk_pins_kind: assert property (cyc_done_o |=>
        {a0_o, upper_byte_enable_n_o, coproc_select_n_o} == {cyc_q[2:1], !cyc_q[0]})
        else $error("lane or select pins wrong");
    chk_read_dir: assert property (!read_n_o |->
        !transceiver_enable_n_o && !transceiver_direction_o) else $error("read buffer");
    chk_write_dir: assert property (!write_n_o |->
        !transceiver_enable_n_o && transceiver_direction_o) else $error("write buffer");
    chk_lock_oe: assert property (!external_reset_n_i |-> lock_oe_n_o)
        else $error("lock pin driven in reset");
    chk_hold_lock: assert property (!ctrl_oe_n_o &&
        (cyc_lock_i || !lock_n_o || !instr_boundary_i || cyc_busy_o) |=> !ctrl_oe_n_o)
        else $error("bus released at wrong time");
    chk_grant_float: assert property (bus_grant_o |-> ctrl_oe_n_o && $past(ctrl_oe_n_o))
        else $error("grant before float");
    chk_grant_keep: assert property (bus_grant_o && hold_i |=> bus_grant_o)
        else $error("grant lost while requested");
    chk_grant_drop: assert property (bus_grant_o && !hold_i |=> !bus_grant_o && !ctrl_oe_n_o)
        else $error("grant kept after request");
    chk_err_int: assert property (numeric_start_i && !coproc_error_n_i |=>
        err_int_o && err_int_type_o == 8'h10) else $error("error interrupt missing");
    cover property (bus_grant_o);
    cover property (err_int_o);
    cover property (cyc_done_o && !ready_i);
endmodule : lbc_checker
bind lbc_top lbc_checker u_lbc_checker (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for lbc_top
// Assumes: Partner model answers ready
// Notes:   Each scenario is one task
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import lbc_pkg::*;
    logic core_clk_i, rst_i, external_reset_n_i, cyc_start_i, cyc_write_i, cyc_coproc_i;
    logic cyc_lock_i, ignore_ready_i, instr_boundary_i, numeric_start_i, ready_i, hold_i;
    logic coproc_error_n_i, cyc_busy_o, cyc_done_o, a0_o, upper_byte_enable_n_o, read_n_o;
    logic write_n_o, transceiver_enable_n_o, transceiver_direction_o, lock_n_o, lock_oe_n_o;
    logic ctrl_oe_n_o, bus_grant_o, coproc_select_n_o, err_int_o, m_en;
    logic [7:0] err_int_type_o;
    logic [3:0] m_wait;
    lbc_xfer_t  cyc_kind_i;
    int         n_errors = 0, compares = 0, cycles = 0;
    lbc_top u_lbc_top (.*);
    lbc_bus_model u_lbc_bus_model (.clk_i(core_clk_i), .busy_i(cyc_busy_o), .en_i(m_en),
        .wait_i(m_wait), .ready_o(ready_i));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic run_cycle(input lbc_xfer_t k, input logic w, cp, ign, input logic [3:0] wt);
        int   i;
        logic rf;
        rf = (k == LBC_XFER_REFRESH);
        @(posedge core_clk_i);
        cyc_kind_i <= k;
        {cyc_write_i, cyc_coproc_i, ignore_ready_i, m_en} <= {w, cp, ign, !ign};
        m_wait <= wt;
        cyc_start_i <= 1'b1;
        @(posedge core_clk_i);
        cyc_start_i <= 1'b0;
        i = 0;
        do begin
            @(posedge core_clk_i);
            #1 i++;
        end while (cyc_done_o !== 1'b1 && i < 20);
        check("done_cycles", i, (ign || wt < 2) ? 1 : wt);
        check("lock_n", lock_n_o, !cyc_lock_i);
        @(posedge core_clk_i);
        #1 check("pins", {a0_o, upper_byte_enable_n_o, read_n_o, write_n_o,
            transceiver_enable_n_o, coproc_select_n_o}, {k, !(!w && !rf), !(w && !rf), rf, !cp});
        if (!rf) check("direction", transceiver_direction_o, w);
    endtask : run_cycle
    task automatic run_hold();
        int i;
        @(posedge core_clk_i);
        {hold_i, cyc_lock_i} <= 2'h3;
        run_cycle(LBC_XFER_WORD, 1'b0, 1'b0, 1'b0, 4'h0);
        repeat (2) @(posedge core_clk_i);
        #1 check("grant_locked", bus_grant_o, 1'b0);
        @(posedge core_clk_i);
        cyc_lock_i <= 1'b0;
        i = 0;
        do begin
            @(posedge core_clk_i);
            #1 i++;
        end while (bus_grant_o !== 1'b1 && i < 10);
        check("grant_wait", i, 2);
        check("floated", ctrl_oe_n_o, 1'b1);
        repeat (3) @(posedge core_clk_i);
        #1 check("grant_held", bus_grant_o, 1'b1);
        @(posedge core_clk_i);
        cyc_start_i <= 1'b1;
        @(posedge core_clk_i);
        {cyc_start_i, hold_i} <= 2'h0;
        #1 check("start_refused", cyc_busy_o, 1'b0);
        @(posedge core_clk_i);
        #1 check("grant_drop", {bus_grant_o, ctrl_oe_n_o}, 2'h0);
    endtask : run_hold
    task automatic run_err(input logic e);
        @(posedge core_clk_i);
        {numeric_start_i, coproc_error_n_i} <= {1'b1, e};
        @(posedge core_clk_i);
        numeric_start_i <= 1'b0;
        #1 check("err_int", err_int_o, !e);
        check("err_type", err_int_type_o, 8'h10);
    endtask : run_err
    task automatic run_ext_reset();
        @(posedge core_clk_i);
        external_reset_n_i <= 1'b0;
        @(posedge core_clk_i);
        #1 check("lock_oe_n", lock_oe_n_o, 1'b1);
        @(posedge core_clk_i);
        external_reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1 check("lock_oe_n_run", lock_oe_n_o, 1'b0);
    endtask : run_ext_reset
    initial begin
        {rst_i, external_reset_n_i, instr_boundary_i, coproc_error_n_i} = 4'hf;
        {cyc_start_i, cyc_write_i, cyc_coproc_i, cyc_lock_i} = 4'h0;
        {ignore_ready_i, numeric_start_i, hold_i, m_en} = 4'h0;
        cyc_kind_i = LBC_XFER_WORD;
        m_wait = 4'h0;
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            run_cycle(lbc_xfer_t'(k), k[0], k == 2, 1'b0, 4'(k));
        end
        run_cycle(LBC_XFER_ODD, 1'b0, 1'b1, 1'b0, 4'h0);
        run_cycle(LBC_XFER_EVEN, 1'b1, 1'b0, 1'b1, 4'h5);
        run_hold();
        run_cycle(LBC_XFER_WORD, 1'b1, 1'b0, 1'b0, 4'h2);
        run_err(1'b0);
        run_err(1'b1);
        run_ext_reset();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
